/* File: src/twi_client_pkg.sv */
// package: register map, field positions, reset values and commands for the i2c client block
package twi_client_pkg;
    // register indices (printed offsets are indices; byte address = 4 * index)
    localparam logic [3:0]  idx_control      = 4'h8;  // client_control_a
    localparam logic [3:0]  idx_control_b    = 4'h9;  // client_control_b
    localparam logic [3:0]  idx_status       = 4'ha;  // client_status_reg
    localparam logic [3:0]  idx_own_id       = 4'hc;  // client_own_id
    localparam logic [3:0]  idx_byte_buffer  = 4'hd;  // client_byte_buffer
    localparam logic [3:0]  idx_match_mask   = 4'he;  // client_match_mask
    localparam logic [3:0]  idx_host_ctrl    = 4'h3;  // host_control_a / dual_mode_control
    // control register fields
    localparam int          ctl_enable       = 0;
    localparam int          ctl_auto_ack     = 1;
    localparam int          ctl_accept_all   = 2;
    // control b fields
    localparam int          ctb_cmd_lo       = 0;
    localparam int          ctb_ack_sel      = 2;
    // host control fields
    localparam int          hc_host_enable   = 0;
    localparam int          hc_dual_enable   = 1;
    localparam int          hc_ratio_ok      = 2;
    // status fields
    localparam int          st_cause         = 0;
    localparam int          st_dir           = 1;
    localparam int          st_bus_err       = 2;
    localparam int          st_rx_ack        = 4;
    localparam int          st_stretch       = 5;
    localparam int          st_match_stop    = 6;
    localparam int          st_data_flag     = 7;
    // mask register select bit
    localparam int          mask_select_bit  = 0;
    // reset value and general call id
    localparam logic [7:0]  reset_byte       = 8'h00;
    localparam logic [7:0]  general_call_id  = 8'h00;
    // commands
    localparam logic [1:0]  cmd_none         = 2'h0;
    localparam logic [1:0]  cmd_complete     = 2'h2;
    localparam logic [1:0]  cmd_response     = 2'h3;
endpackage

/* File: src/twi_sync_bit.sv */
// two flip-flop synchroniser for a single level
`timescale 1ns/1ns
module twi_sync_bit (
    input  wire logic clk,      // destination clock
    input  wire logic rst_n,    // asynchronous reset, active low
    input  wire logic d,        // level from another domain
    output logic      q         // synchronised level
);
    logic meta;
    logic next_meta;
    logic next_q;

    // first stage feeds only the second
    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    // register both stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

/* File: src/twi_link_side.sv */
// bus-facing serial engine: start/stop detection, byte shifting, ack and clock stretch
`timescale 1ns/1ns
module twi_link_side (
    input  wire logic       link_clk,     // link oversampling clock
    input  wire logic       rst_n,        // asynchronous reset, active low
    input  wire logic       scl_in,       // serial clock level
    input  wire logic       sda_in,       // serial data level
    output logic            scl_oe,       // drive scl low
    output logic            sda_oe,       // drive sda low
    input  wire logic       hold_req,     // synchronised stretch request
    input  wire logic       ack_nack,     // ack value to drive (1 = nack)
    input  wire logic [7:0] tx_byte,      // byte to send on reads
    input  wire logic       resume_tgl,   // synchronised resume toggle
    output logic [7:0]      rx_byte,      // last received byte
    output logic            addr_tgl,     // toggles when an address byte completes
    output logic            data_tgl,     // toggles when a data byte completes
    output logic            stop_tgl,     // toggles on stop condition
    output logic            err_tgl,      // toggles on illegal start/stop
    output logic            host_nack     // last ack bit from host
);
    logic [1:0] scl_s, sda_s, next_scl_s, next_sda_s;
    logic       scl_d, sda_d, next_scl_d, next_sda_d;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg, next_rx;
    logic       first, next_first, busy, next_busy, nb, next_nb;
    logic       sda_drv, next_sda_drv, res_d, next_res_d;
    logic       dir_rd, next_dir_rd, settle, next_settle, stay;
    logic       next_addr_tgl, next_data_tgl, next_stop_tgl, next_err_tgl, next_host_nack;
    logic       rise, fall, start_c, stop_c;

    assign rise    = scl_s[1] & ~scl_d;
    assign fall    = ~scl_s[1] & scl_d;
    assign start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign stop_c  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    // keep scl held after resume until the ack or data bit has settled on sda
    assign stay    = busy & (nb | settle | (res_d != resume_tgl));
    assign scl_oe  = (hold_req | stay) & ~scl_s[1];
    assign sda_oe  = sda_drv;

    // next state for the bit engine
    always_comb begin
        next_scl_s = {scl_s[0], scl_in};
        next_sda_s = {sda_s[0], sda_in};
        next_scl_d = scl_s[1];
        next_sda_d = sda_s[1];
        next_bitcnt = bitcnt; next_shreg = shreg; next_rx = rx_byte;
        next_first = first; next_busy = busy; next_nb = nb; next_sda_drv = sda_drv;
        next_res_d = resume_tgl;
        next_dir_rd = dir_rd;
        next_settle = 1'b0;
        next_addr_tgl = addr_tgl; next_data_tgl = data_tgl;
        next_stop_tgl = stop_tgl; next_err_tgl = err_tgl; next_host_nack = host_nack;
        if (start_c) begin
            if (busy && bitcnt == 4'h1 && first) next_err_tgl = ~err_tgl;
            next_busy = 1'b1; next_first = 1'b1; next_bitcnt = 4'h0; next_sda_drv = 1'b0;
        end else if (stop_c) begin
            if (!busy || (first && bitcnt != 4'h0)) next_err_tgl = ~err_tgl;
            else next_stop_tgl = ~stop_tgl;
            next_busy = 1'b0; next_sda_drv = 1'b0;
        end else if (busy && rise && bitcnt < 4'h8) begin
            next_shreg = {shreg[6:0], sda_s[1]};
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
                next_rx = {shreg[6:0], sda_s[1]};
                if (first) next_addr_tgl = ~addr_tgl;
                else next_data_tgl = ~data_tgl;
                if (first) next_dir_rd = sda_s[1];
            end
        end else if (busy && rise && bitcnt == 4'h8) begin
            next_host_nack = sda_s[1];
            next_bitcnt = 4'h0;
            next_first = 1'b0;
        end
        // place ack or data while scl is still held, release it a cycle later
        if (!busy) begin
            next_nb = 1'b0;
        end else if (res_d != resume_tgl) begin
            next_nb = 1'b1;
        end
        if (busy && nb && !scl_s[1]) begin
            next_sda_drv = dir_rd & ~first ? ~tx_byte[7] : ~ack_nack;
            next_nb = 1'b0;
            next_settle = 1'b1;
        end else if (busy && fall && bitcnt == 4'h0 && !nb) begin
            next_sda_drv = 1'b0;
        end
    end

    // register the bit engine
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 2'h3; sda_s <= 2'h3; scl_d <= 1'b1; sda_d <= 1'b1;
            bitcnt <= 4'h0; shreg <= 8'h00; rx_byte <= 8'h00;
            first <= 1'b0; busy <= 1'b0; nb <= 1'b0; sda_drv <= 1'b0; res_d <= 1'b0;
            addr_tgl <= 1'b0; data_tgl <= 1'b0; stop_tgl <= 1'b0; err_tgl <= 1'b0;
            host_nack <= 1'b0;
            dir_rd <= 1'b0;
            settle <= 1'b0;
        end else begin
            scl_s <= next_scl_s; sda_s <= next_sda_s; scl_d <= next_scl_d; sda_d <= next_sda_d;
            bitcnt <= next_bitcnt; shreg <= next_shreg; rx_byte <= next_rx;
            first <= next_first; busy <= next_busy; nb <= next_nb; sda_drv <= next_sda_drv;
            res_d <= next_res_d;
            dir_rd <= next_dir_rd;
            settle <= next_settle;
            addr_tgl <= next_addr_tgl; data_tgl <= next_data_tgl;
            stop_tgl <= next_stop_tgl; err_tgl <= next_err_tgl; host_nack <= next_host_nack;
        end
    end
endmodule

/* File: src/twi_client_address_data.sv */
// i2c client: address match, direction/cause status, data buffer with auto acknowledge
`timescale 1ns/1ns
module twi_client_address_data (
    input  wire logic        pclk,       // apb clock, 10 mhz
    input  wire logic        presetn,    // asynchronous reset, active low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic [31:0]      prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error on unmapped address
    input  wire logic        link_clk,   // link oversampling clock
    input  wire logic        scl_in,     // serial clock pin level
    output logic             scl_out,    // serial clock drive value
    output logic             scl_oe,     // serial clock drive enable
    input  wire logic        sda_in,     // serial data pin level
    output logic             sda_out,    // serial data drive value
    output logic             sda_oe      // serial data drive enable
);
    // ************************************************************
    // registers and signals
    // ************************************************************
    logic [7:0] client_control_a, next_ctl;
    logic [7:0] host_control_a, next_hc;
    logic       ack_response_select, next_ack;
    logic [7:0] client_own_id, next_own;
    logic [7:0] client_byte_buffer, next_buf;
    logic [7:0] client_match_mask, next_mask;
    logic       match_or_stop_flag, next_flag;
    logic       data_flag, next_dflag;
    logic       event_cause_bit, next_cause;
    logic       direction, next_dir;
    logic       bus_error, next_berr;
    logic       resume_tgl, next_resume;
    logic [3:0] tgl_d, next_tgl_d;
    logic       clock_stretch_active;
    logic       wr, rd, mapped, release_hold;
    logic [6:0] rx_id, match_mask_field;
    logic       second_id_select, id_match;
    logic [3:0] tgl_link, tgl_sync;
    logic       hold_sync, ack_sync, resume_sync, rx_nack_link, host_nack;
    logic [7:0] rx_link;
    logic [7:0] rdata;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ************************************************************
    // link domain engine and crossings
    // ************************************************************
    twi_link_side link (
        .link_clk   (link_clk),
        .rst_n      (presetn),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .scl_oe     (scl_oe),
        .sda_oe     (sda_oe),
        .hold_req   (hold_sync),
        .ack_nack   (ack_sync),
        .tx_byte    (client_byte_buffer),
        .resume_tgl (resume_sync),
        .rx_byte    (rx_link),
        .addr_tgl   (tgl_link[0]),
        .data_tgl   (tgl_link[1]),
        .stop_tgl   (tgl_link[2]),
        .err_tgl    (tgl_link[3]),
        .host_nack  (rx_nack_link)
    );

    // events from the link cross as toggles
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : ev_sync
            twi_sync_bit s (.clk(pclk), .rst_n(presetn), .d(tgl_link[g]), .q(tgl_sync[g]));
        end
    endgenerate
    twi_sync_bit s_nack (.clk(pclk), .rst_n(presetn), .d(rx_nack_link), .q(host_nack));
    // stretch request, ack value and resume cross to the link
    twi_sync_bit s_hold (.clk(link_clk), .rst_n(presetn), .d(clock_stretch_active),
                         .q(hold_sync));
    twi_sync_bit s_ack (.clk(link_clk), .rst_n(presetn), .d(ack_response_select),
                        .q(ack_sync));
    twi_sync_bit s_res (.clk(link_clk), .rst_n(presetn), .d(resume_tgl), .q(resume_sync));

    // ************************************************************
    // address match
    // ************************************************************
    assign rx_id            = rx_link[7:1];
    assign match_mask_field = client_match_mask[7:1];
    assign second_id_select = client_match_mask[twi_client_pkg::mask_select_bit];

    // decide whether the received id addresses this client
    always_comb begin
        id_match = 1'b0;
        if (client_control_a[twi_client_pkg::ctl_accept_all]) begin
            id_match = 1'b1;
        end else if (second_id_select) begin
            id_match = (rx_id == client_own_id[7:1]) || (rx_id == match_mask_field);
        end else begin
            id_match = ((rx_id ^ client_own_id[7:1]) & ~match_mask_field) == 7'h00;
        end
        if (client_own_id[0] && rx_link == twi_client_pkg::general_call_id) begin
            id_match = 1'b1;
        end
    end

    // ************************************************************
    // register file and status
    // ************************************************************
    assign clock_stretch_active = match_or_stop_flag & event_cause_bit | data_flag;
    assign mapped = paddr[1:0] == 2'h0 && (paddr[5:2] == twi_client_pkg::idx_control ||
        paddr[5:2] == twi_client_pkg::idx_control_b || paddr[5:2] == twi_client_pkg::idx_status ||
        paddr[5:2] == twi_client_pkg::idx_own_id || paddr[5:2] == twi_client_pkg::idx_byte_buffer ||
        paddr[5:2] == twi_client_pkg::idx_match_mask || paddr[5:2] == twi_client_pkg::idx_host_ctrl)
        && paddr[7:6] == 2'h0;
    assign pslverr = psel & penable & ~mapped;

    // read mux
    always_comb begin
        rdata = 8'h00;
        if (paddr[5:2] == twi_client_pkg::idx_control) rdata = client_control_a;
        if (paddr[5:2] == twi_client_pkg::idx_control_b) rdata = {5'h00, ack_response_select, 2'h0};
        if (paddr[5:2] == twi_client_pkg::idx_status) begin
            rdata = {data_flag, match_or_stop_flag, clock_stretch_active, host_nack,
                     1'b0, bus_error, direction, event_cause_bit};
        end
        if (paddr[5:2] == twi_client_pkg::idx_own_id) rdata = client_own_id;
        if (paddr[5:2] == twi_client_pkg::idx_byte_buffer) rdata = client_byte_buffer;
        if (paddr[5:2] == twi_client_pkg::idx_match_mask) rdata = client_match_mask;
        if (paddr[5:2] == twi_client_pkg::idx_host_ctrl) rdata = host_control_a;
        if (!mapped) rdata = 8'h00;
    end
    assign prdata = {24'h000000, rdata};

    // next values for registers and flags
    always_comb begin
        next_ctl = client_control_a; next_hc = host_control_a; next_ack = ack_response_select;
        next_own = client_own_id; next_buf = client_byte_buffer; next_mask = client_match_mask;
        next_flag = match_or_stop_flag; next_dflag = data_flag; next_cause = event_cause_bit;
        next_dir = direction; next_berr = bus_error; next_resume = resume_tgl;
        next_tgl_d = tgl_sync;
        release_hold = 1'b0;
        if (wr && mapped) begin
            unique case (paddr[5:2])
                twi_client_pkg::idx_control: next_ctl = pwdata[7:0];
                twi_client_pkg::idx_host_ctrl: next_hc = pwdata[7:0];
                twi_client_pkg::idx_own_id: next_own = pwdata[7:0];
                twi_client_pkg::idx_match_mask: next_mask = pwdata[7:0];
                twi_client_pkg::idx_control_b: begin
                    next_ack = pwdata[twi_client_pkg::ctb_ack_sel];
                    if (pwdata[1:0] == twi_client_pkg::cmd_complete ||
                        pwdata[1:0] == twi_client_pkg::cmd_response) release_hold = 1'b1;
                end
                twi_client_pkg::idx_status: begin
                    if (pwdata[twi_client_pkg::st_bus_err]) next_berr = 1'b0;
                    if (pwdata[twi_client_pkg::st_match_stop]) next_flag = 1'b0;
                    if (pwdata[twi_client_pkg::st_data_flag]) next_dflag = 1'b0;
                end
                twi_client_pkg::idx_byte_buffer: begin
                    if (clock_stretch_active) begin
                        next_buf = pwdata[7:0];
                        release_hold = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // auto-ack read of the buffer during hold resumes the bus
        if (rd && paddr[5:2] == twi_client_pkg::idx_byte_buffer && clock_stretch_active &&
            client_control_a[twi_client_pkg::ctl_auto_ack]) begin
            release_hold = 1'b1;
        end
        if (release_hold) begin
            next_flag = 1'b0;
            next_dflag = 1'b0;
            next_resume = ~resume_tgl;
        end
        // hardware events win over clears
        if ((tgl_sync[0] ^ tgl_d[0]) && client_control_a[twi_client_pkg::ctl_enable] &&
            id_match) begin
            next_flag = 1'b1;
            next_cause = 1'b1;
            next_dir = rx_link[0];
        end
        if ((tgl_sync[1] ^ tgl_d[1]) && client_control_a[twi_client_pkg::ctl_enable]) begin
            next_dflag = 1'b1;
            next_buf = rx_link;
        end
        if ((tgl_sync[2] ^ tgl_d[2]) && client_control_a[twi_client_pkg::ctl_enable]) begin
            next_flag = 1'b1;
            next_cause = 1'b0;
        end
        if ((tgl_sync[3] ^ tgl_d[3]) && host_control_a[twi_client_pkg::hc_ratio_ok] &&
            (host_control_a[twi_client_pkg::hc_host_enable] ||
             host_control_a[twi_client_pkg::hc_dual_enable])) begin
            next_berr = 1'b1;
        end
    end

    // register file state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            client_control_a <= twi_client_pkg::reset_byte;
            host_control_a <= twi_client_pkg::reset_byte;
            ack_response_select <= 1'b0;
            client_own_id <= twi_client_pkg::reset_byte;
            client_byte_buffer <= twi_client_pkg::reset_byte;
            client_match_mask <= twi_client_pkg::reset_byte;
            match_or_stop_flag <= 1'b0; data_flag <= 1'b0; event_cause_bit <= 1'b0;
            direction <= 1'b0; bus_error <= 1'b0; resume_tgl <= 1'b0; tgl_d <= 4'h0;
        end else begin
            client_control_a <= next_ctl;
            host_control_a <= next_hc;
            ack_response_select <= next_ack;
            client_own_id <= next_own;
            client_byte_buffer <= next_buf;
            client_match_mask <= next_mask;
            match_or_stop_flag <= next_flag; data_flag <= next_dflag;
            event_cause_bit <= next_cause;
            direction <= next_dir; bus_error <= next_berr; resume_tgl <= next_resume;
            tgl_d <= next_tgl_d;
        end
    end
endmodule

/* File: tb/twi_client_sva.sv */
// checker: apb and pin properties of the i2c client
`timescale 1ns/1ns
module twi_client_sva (
    input wire logic        pclk,     // apb clock
    input wire logic        presetn,  // reset, active low
    input wire logic        psel,     // select
    input wire logic        penable,  // access phase
    input wire logic        pwrite,   // direction
    input wire logic [7:0]  paddr,    // byte address
    input wire logic [31:0] pwdata,   // write data
    input wire logic [31:0] prdata,   // read data
    input wire logic        pready,   // ready
    input wire logic        pslverr,  // error
    input wire logic        scl_out,  // scl drive value
    input wire logic        sda_out   // sda drive value
);
    // ****
    // helper logic
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic err_ok;
    logic next_err_ok;
    logic mapped;
    // remembers that host or dual mode was enabled with the clock ratio bit
    always_comb begin
        next_err_ok = err_ok | (psel & penable & pwrite & (paddr == 8'h0c) &
                      (pwdata[0] | pwdata[1]) & pwdata[2]);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ok <= 1'b0;
        end else begin
            err_ok <= next_err_ok;
        end
    end
    assign mapped = paddr inside {8'h0c, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38};
    sequence acc;
        psel && penable;
    endsequence
    sequence rd(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    sequence wr(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    ready_now_a: assert property (acc |-> pready) else $error("no ready in access");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray error");
    unmapped_a: assert property (acc ##0 !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc ##0 mapped |-> !pslverr) else $error("mapped refused");
    upper_zero_a: assert property (acc |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    cmd_zero_a: assert property (rd(8'h24) |-> prdata[1:0] == 2'h0) else $error("cmd reads back");
    bus_err_a: assert property (rd(8'h28) ##0 !err_ok |-> !prdata[2])
        else $error("bus error without host or dual");
    mask_back_a: assert property (wr(8'h38) ##3 rd(8'h38) |->
        prdata[7:0] == $past(pwdata[7:0], 3)) else $error("mask readback differs");
    open_drain_a: assert property (!scl_out && !sda_out) else $error("line driven high");
endmodule
bind twi_client_address_data twi_client_sva i_twi_client_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_out, .sda_out);

/* File: tb/twi_host_model.sv */
// i2c bus host model: start, stop and byte transfer with clock stretch
`timescale 1ns/1ns
module twi_host_model #(parameter int half_ns = 1000) (
    input  wire logic scl,     // resolved serial clock
    input  wire logic sda,     // resolved serial data
    output logic      scl_oe,  // pull scl low
    output logic      sda_oe   // pull sda low
);
    // bus idle, both lines released
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // one bit: data set while scl low, clock released, stretch waited out
    task automatic bit_slot(input logic dv, output logic qv);
        sda_oe = !dv;
        #half_ns scl_oe = 1'b0;
        wait (scl);  // client holds scl low while it waits for software
        qv = sda;
        #half_ns scl_oe = 1'b1;
    endtask
    task automatic start();
        sda_oe = 1'b1;
        #half_ns scl_oe = 1'b1;
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        #half_ns scl_oe = 1'b0;
        wait (scl);
        #half_ns sda_oe = 1'b0;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                        output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], rx[i]);
        end
        bit_slot(ai, ao);
    endtask
endmodule

/* File: tb/testbench.sv */
// testbench: register, address match and data checks against an i2c host model
`timescale 1ns/1ns
module testbench;
    logic        pclk, presetn, link_clk, psel, penable, pwrite, e, ak, m;
    logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, h_scl, h_sda;
    logic [7:0]  paddr, rx, st;
    logic [31:0] pwdata, prdata, q, c, d;
    int          fail_count, n_checks, seed;
    wire         scl_in = !(scl_oe || h_scl);  // open drain lines with pull-up
    wire         sda_in = !(sda_oe || h_sda);
    logic [31:0] cases [9] = '{32'h54000154, 32'h54000155, 32'h54000156, 32'h55000100,
        32'h54060150, 32'h54330132, 32'h54330156, 32'h540005a7, 32'h54000100};
    twi_client_address_data i_twi_client_address_data (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .scl_in, .scl_out,
        .scl_oe, .sda_in, .sda_out, .sda_oe);
    twi_host_model i_twi_host_model (.scl(scl_in), .sda(sda_in), .scl_oe(h_scl), .sda_oe(h_sda));
    // clocks: 100 ns apb, 125 ns link at an unrelated phase
    initial begin
        pclk = 1'b0;
        forever #50 pclk = !pclk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dv;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        do apb(1'b0, 8'h28, 32'h0); while (q[b] !== v);
        st = q[7:0];
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // reference address match
    function automatic logic hit(logic [7:0] own, logic [7:0] msk, logic all, logic [7:0] ab);
        if (all) return 1'b1;
        if (own[0] && ab == 8'h00) return 1'b1;
        if (msk[0]) return ab[7:1] == own[7:1] || ab[7:1] == msk[7:1];
        return ((ab[7:1] ^ own[7:1]) & ~msk[7:1]) == 7'h00;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #5_000_000;
        fail_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fail_count = 0;
        n_checks = 0;
        seed = 11412;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 8'h30; a <= 8'h3c; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk({q[30:0], e}, {31'h0, a == 8'h3c});
        end
        repeat (4) begin
            d = $random(seed);
            apb(1'b1, 8'h30, d);
            apb(1'b1, 8'h38, d ^ 32'h5a);
            apb(1'b0, 8'h38, 32'h0);
            chk(q, (d ^ 32'h5a) & 32'hff);
            apb(1'b0, 8'h30, 32'h0);
            chk(q, d & 32'hff);
        end
        foreach (cases[i]) begin
            c = cases[i];
            apb(1'b1, 8'h30, c[31:24]);
            apb(1'b1, 8'h38, c[23:16]);
            apb(1'b1, 8'h20, c[15:8]);
            m = hit(c[31:24], c[23:16], c[10], c[7:0]);
            fork
                begin
                    i_twi_host_model.start();
                    i_twi_host_model.xfer(c[7:0], 1'b1, rx, ak);
                    i_twi_host_model.stop();
                end
                if (m) begin
                    poll(5, 1'b1);
                    chk(st & 8'he7, 8'h61 | {c[0], 1'b0});
                    apb(1'b1, 8'h24, {c[1], 2'h2});
                end
            join
            chk(ak, !m || c[1]);
            if (m) begin
                poll(0, 1'b0);
                chk(st & 8'he7, 8'h40 | {c[0], 1'b0});
            end
            apb(1'b1, 8'h28, 32'hc4);
        end
        d = $random(seed);
        apb(1'b1, 8'h20, 32'h3);
        fork
            begin
                i_twi_host_model.start();
                i_twi_host_model.xfer(8'h54, 1'b1, rx, ak);
                i_twi_host_model.xfer(d[7:0], 1'b1, rx, ak);
                i_twi_host_model.stop();
            end
            begin
                poll(5, 1'b1);
                apb(1'b1, 8'h24, 32'h3);
                poll(7, 1'b1);
                apb(1'b0, 8'h34, 32'h0);
                chk(q, d & 32'hff);
            end
        join
        chk(ak, 1'b0);
        apb(1'b1, 8'h28, 32'hc4);
        for (int h = 0; h < 8; h += 7) begin
            apb(1'b1, 8'h0c, h);
            i_twi_host_model.start();
            i_twi_host_model.stop();
            poll(2, h[0]);
            chk(st[2], h[0]);
            apb(1'b1, 8'h28, 32'hc4);
        end
        wrap_up();
    end
endmodule
